// >>> rtl/mlm_pkg.sv
/*
  Constants shared by the literal-move and literal-multiply execution logic.
  Assumes a 12-bit data address space and a 4-bit bank select value.
*/
// Summary of operation
// - Load literal into working register, flags kept
// - Store working register into addressed file location
// - File field reaches any byte of bank
// - Bank bit zero selects fixed access bank
// - Bank bit one takes bank select register
// - Extended set, bank bit zero, low offsets use indexed addressing
// - Unsigned 16-bit product, working register unchanged
// - High byte upper product, low byte lower
// - Multiply leaves every status flag alone
// - Zero product raises no zero flag
package mlm_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 12;                   // Data address width
  localparam int BANK_W = 4;                    // Bank select width

  // ==========================================================
  // Opcode fields
  localparam logic [7:0] OPC_LOAD  = 8'h0e;     // Upper byte, literal load
  localparam logic [7:0] OPC_MUL   = 8'h0d;     // Upper byte, literal multiply
  localparam logic [6:0] OPC_STORE = 7'h37;     // Upper seven bits, store
  localparam int         BANK_BIT  = 8;         // Position of bank bit

  // ==========================================================
  // Addressing constants
  localparam logic [7:0]        ILO_LIMIT     = 8'h5f; // Highest indexed offset
  localparam logic [7:0]        ACCESS_SPLIT  = 8'h80; // Access bank upper half
  localparam logic [BANK_W-1:0] ACCESS_LO_BNK = 4'h0;  // Lower half bank
  localparam logic [BANK_W-1:0] ACCESS_HI_BNK = 4'hf;  // Upper half bank

  // ==========================================================
  // Reset values
  localparam logic [7:0]  W_RESET    = 8'h00;   // Working register
  localparam logic [15:0] PROD_RESET = 16'h0000; // Product pair

  // Execution phases of one instruction cycle
  typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} mlm_phase_t;

endpackage

// >>> rtl/mlm_dec_if.sv
/*
  Carrier between the execution core and its opcode decoder.
  Assumes purely combinational decode on the core clock.
*/
`timescale 1ns/100ps
interface mlm_dec_if;
  logic [15:0] instr;     // Instruction word under decode
  logic        isLoad;    // Literal load opcode
  logic        isStore;   // Store working opcode
  logic        isMul;     // Literal multiply opcode
  logic        bankBit;   // Access/bank selector bit
  logic [7:0]  operand;   // Literal or file field

  modport dec
  (
    input  instr,
    output isLoad,
    output isStore,
    output isMul,
    output bankBit,
    output operand
  );
  modport core
  (
    output instr,
    input  isLoad,
    input  isStore,
    input  isMul,
    input  bankBit,
    input  operand
  );
endinterface

// >>> rtl/mlm_decoder.sv
/*
  Opcode decoder for the three literal/store instructions.
  Assumes the instruction word is stable while decoded.
*/
`timescale 1ns/100ps
module mlm_decoder
(
  // Decode carrier
  mlm_dec_if.dec dif
);

  // ==========================================================
  // Opcode matching
  // Compare upper byte against a fixed opcode
  function automatic logic matchByte(input logic [15:0] w, input logic [7:0] opc);
    matchByte = (w[15:8] == opc);
  endfunction

  assign dif.isLoad  = matchByte(dif.instr, mlm_pkg::OPC_LOAD);
  assign dif.isMul   = matchByte(dif.instr, mlm_pkg::OPC_MUL);
  assign dif.isStore = (dif.instr[15:9] == mlm_pkg::OPC_STORE);
  assign dif.bankBit = dif.instr[mlm_pkg::BANK_BIT];
  // Low byte is literal or file offset alike
  assign dif.operand = dif.instr[7:0];

endmodule

// >>> rtl/mlm_core_exec.sv
/*
  Execution of literal load, working-register store and literal multiply.
  Each accepted instruction runs four phases: decode, read, process, write.
  Assumes instrValid and the core inputs come from logic on sys_clk, so
  they are not synchronised. Only one instruction is in flight at a time.
*/
`timescale 1ns/100ps
module mlm_core_exec
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  // Instruction fetch side
  input  wire logic                       instrValid,
  input  wire logic [15:0]                instrWord,
  // Core context
  input  wire logic [mlm_pkg::BANK_W-1:0] bankSelect,
  input  wire logic                       extSetEnable,
  input  wire logic [mlm_pkg::ADDR_W-1:0] indexBase,
  // Architectural registers
  output logic      [7:0]                 working,
  output logic      [7:0]                 productHigh,
  output logic      [7:0]                 productLow,
  // Data memory write port
  output logic                            memWrEn,
  output logic      [mlm_pkg::ADDR_W-1:0] memWrAddr,
  output logic      [7:0]                 memWrData,
  // Sequencing
  output logic                            busy,
  output logic                            done
);

  // ==========================================================
  // Declarations
  mlm_pkg::mlm_phase_t phase;                       // Current phase
  mlm_pkg::mlm_phase_t next_phase;                  // Next phase
  logic [15:0]                instrReg;             // Captured instruction
  logic                       opLoad;               // Decoded load
  logic                       opStore;              // Decoded store
  logic                       opMul;                // Decoded multiply
  logic                       opBank;               // Decoded bank bit
  logic [7:0]                 opField;              // Decoded low byte
  logic [7:0]                 operandA;             // Working value read
  logic [15:0]                product;              // Processed product
  logic [mlm_pkg::ADDR_W-1:0] storeAddr;            // Processed address
  logic                       accept;               // New instruction taken
  logic                       useIndexed;           // Indexed offset mode
  logic [mlm_pkg::ADDR_W-1:0] accessAddr;           // Access bank address
  logic [mlm_pkg::ADDR_W-1:0] next_addr;            // Address being formed
  logic [15:0]                next_product;         // Product being formed

  mlm_dec_if dif ();                                // Decoder carrier

  // ==========================================================
  // Decoder
  assign dif.instr = instrReg;

  mlm_decoder u_dec
  (
    .dif (dif.dec)
  );

  // ==========================================================
  // Combinational datapath
  assign accept = instrValid && (phase == mlm_pkg::PH_IDLE);

  // Indexed mode only with extended set on, bank bit clear and a low offset
  assign useIndexed = !opBank && extSetEnable && (opField <= mlm_pkg::ILO_LIMIT);

  // Access bank splits into bottom of bank 0 and top of last bank
  assign accessAddr = (opField >= mlm_pkg::ACCESS_SPLIT) ?
                      {mlm_pkg::ACCESS_HI_BNK, opField} :
                      {mlm_pkg::ACCESS_LO_BNK, opField};

  // Whole 8-bit field is the offset inside the chosen bank, or is added to indexBase in indexed mode
  assign next_addr = opBank     ? {bankSelect, opField} :
                     useIndexed ? mlm_pkg::ADDR_W'(indexBase + 12'(opField)) :
                                  accessAddr;

  // Unsigned product needs no sign handling and cannot overflow 16 bits
  assign next_product = 16'(operandA) * 16'(opField);

  // ==========================================================
  // Phase sequencing
  // Four phases per instruction, then back to idle
  always_comb
  begin
    next_phase = phase;
    case (phase)
      mlm_pkg::PH_IDLE:    next_phase = accept ? mlm_pkg::PH_DECODE : mlm_pkg::PH_IDLE;
      mlm_pkg::PH_DECODE:  next_phase = mlm_pkg::PH_READ;
      mlm_pkg::PH_READ:    next_phase = mlm_pkg::PH_PROCESS;
      mlm_pkg::PH_PROCESS: next_phase = mlm_pkg::PH_WRITE;
      mlm_pkg::PH_WRITE:   next_phase = mlm_pkg::PH_IDLE;
      default:             next_phase = mlm_pkg::PH_IDLE;
    endcase
  end

  // Phase register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      phase <= mlm_pkg::PH_IDLE;
    else
      phase <= next_phase;
  end

  // Capture the instruction word when taken
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      instrReg <= 16'h0000;
    else if (accept)
      instrReg <= instrWord;
  end

  // ==========================================================
  // Decode phase: latch decoded kind and field
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      opLoad  <= 1'b0;
      opStore <= 1'b0;
      opMul   <= 1'b0;
      opBank  <= 1'b1;
      opField <= 8'h00;
    end
    else if (phase == mlm_pkg::PH_DECODE)
    begin
      // Unknown opcodes decode to nothing and run as no-operation
      opLoad  <= dif.isLoad;
      opStore <= dif.isStore;
      opMul   <= dif.isMul;
      opBank  <= dif.bankBit;
      opField <= dif.operand;
    end
  end

  // ==========================================================
  // Read and process phases
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      operandA  <= 8'h00;
      product   <= mlm_pkg::PROD_RESET;
      storeAddr <= '0;
    end
    else
    begin
      // Read the working register for store and multiply
      if (phase == mlm_pkg::PH_READ)
        operandA <= working;
      if (phase == mlm_pkg::PH_PROCESS)
      begin
        product   <= next_product;
        storeAddr <= next_addr;
      end
    end
  end

  // ==========================================================
  // Write phase: destinations update only here
  // No status flag logic exists here; zero products are not flagged
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      working <= mlm_pkg::W_RESET;
    else if (phase == mlm_pkg::PH_WRITE && opLoad)
      working <= opField;
  end

  // Product pair split into its two bytes
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      productHigh <= mlm_pkg::PROD_RESET[15:8];
      productLow  <= mlm_pkg::PROD_RESET[7:0];
    end
    else if (phase == mlm_pkg::PH_WRITE && opMul)
    begin
      productHigh <= product[15:8];
      productLow  <= product[7:0];
    end
  end

  // Memory write strobe, one cycle per store
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memWrEn   <= 1'b0;
      memWrAddr <= '0;
      memWrData <= 8'h00;
    end
    else
    begin
      memWrEn <= (phase == mlm_pkg::PH_WRITE) && opStore;
      if (phase == mlm_pkg::PH_WRITE && opStore)
      begin
        memWrAddr <= storeAddr;
        memWrData <= operandA;
      end
    end
  end

  // Busy across the four phases, done on completion
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      busy <= (next_phase != mlm_pkg::PH_IDLE);
      done <= (phase == mlm_pkg::PH_WRITE);
    end
  end

  // ==========================================================
  // Assertions
  sequence s_takeLoad;
    accept && (instrWord[15:8] == mlm_pkg::OPC_LOAD);
  endsequence
  sequence s_takeMul;
    accept && (instrWord[15:8] == mlm_pkg::OPC_MUL);
  endsequence
  sequence s_takeStore;
    accept && (instrWord[15:9] == mlm_pkg::OPC_STORE);
  endsequence

  a_load_sets_w: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_takeLoad |-> ##5 (working == $past(instrWord[7:0], 5)))
    else $error("literal load did not reach working register");

  a_store_data: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_takeStore |-> ##5 (memWrEn && memWrData == $past(working, 5)))
    else $error("store did not write working value");

  a_store_banked: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_takeStore and (instrWord[8] == 1'b1)) |->
      ##5 (memWrAddr == {$past(bankSelect, 2), $past(instrWord[7:0], 5)}))
    else $error("banked store address wrong");

  a_store_access: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_takeStore and (instrWord[8] == 1'b0)) |-> ##3 !extSetEnable |->
      ##2 (memWrAddr[7:0] == $past(instrWord[7:0], 5) &&
           memWrAddr[11:8] == ($past(instrWord[7], 5) ? 4'hf : 4'h0)))
    else $error("access bank store address wrong");

  a_store_indexed: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_takeStore and (instrWord[8] == 1'b0) and (instrWord[7:0] <= 8'h5f)) |->
      ##3 extSetEnable |-> ##2
      (memWrAddr == 12'($past(indexBase, 2) + 12'($past(instrWord[7:0], 5)))))
    else $error("indexed store address wrong");

  a_mul_product: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_takeMul |-> ##5
      ({productHigh, productLow} == 16'($past(working, 5)) * 16'($past(instrWord[7:0], 5))))
    else $error("product pair wrong");

  a_mul_keeps_w: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_takeMul |-> ##5 (working == $past(working, 5)) && !memWrEn)
    else $error("multiply disturbed working register");

  a_four_phases: assert property (@(posedge sys_clk) disable iff (!arst_n)
    accept |=> (busy && !done) [*4] ##1 (done && !busy))
    else $error("instruction cycle not four phases");

  a_wr_only_store: assert property (@(posedge sys_clk) disable iff (!arst_n)
    memWrEn |-> $past(opStore) && ($past(instrReg[15:9]) == mlm_pkg::OPC_STORE))
    else $error("memory write without store opcode");

endmodule

// >>> dv/tb_top.sv
/*
  Self-checking bench for the literal load, working store and literal
  multiply execution block. A queue of instructions runs through an
  integer model and the results are compared at every done pulse.
  Assumes the design package and block are compiled before this file.
*/
`timescale 1ns/100ps
module tb_top;
  // ==========================================================
  // Stimulus and observation signals
  logic                       sys_clk;      // Core clock, 100 MHz
  logic                       arst_n;       // Async reset, low active
  logic                       instrValid;   // Instruction offered
  logic [15:0]                instrWord;    // Instruction word
  logic [mlm_pkg::BANK_W-1:0] bankSelect;   // Bank select value
  logic                       extSetEnable; // Extended set on
  logic [mlm_pkg::ADDR_W-1:0] indexBase;    // Indexed offset base
  logic [7:0]                 working;      // Working register
  logic [7:0]                 productHigh;  // Upper product byte
  logic [7:0]                 productLow;   // Lower product byte
  logic                       memWrEn;      // Write strobe
  logic [mlm_pkg::ADDR_W-1:0] memWrAddr;    // Write address
  logic [7:0]                 memWrData;    // Write data
  logic                       busy;         // Instruction in flight
  logic                       done;         // Completion pulse

  // Model state and bookkeeping
  int          fail_count;                  // Mismatches seen
  int          compares;                    // Comparisons made
  int          mW;                          // Model working register
  int          mProd;                       // Model product pair
  logic [31:0] rng;                         // Xorshift state

  // ==========================================================
  // Design under test
  mlm_core_exec DUT
  (
    .sys_clk      (sys_clk),
    .arst_n       (arst_n),
    .instrValid   (instrValid),
    .instrWord    (instrWord),
    .bankSelect   (bankSelect),
    .extSetEnable (extSetEnable),
    .indexBase    (indexBase),
    .working      (working),
    .productHigh  (productHigh),
    .productLow   (productLow),
    .memWrEn      (memWrEn),
    .memWrAddr    (memWrAddr),
    .memWrData    (memWrData),
    .busy         (busy),
    .done         (done)
  );

  // Free-running clock, 10 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Helpers
  // Xorshift step, fixed seed keeps runs repeatable
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // One comparison; unknowns never match
  task automatic chk(input string n, input int e, input logic [15:0] g);
    compares++;
    if (g !== 16'(e))
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Offer one instruction, wait for done, compare with the model
  task automatic run(input logic [15:0] w, input logic [3:0] bs, input logic ex,
                     input logic [11:0] ib);
    int   i;
    int   k;
    int   addr;
    logic got;
    logic isSt;
    k    = int'(w[7:0]);
    isSt = (w[15:9] == 7'h37);
    @(posedge sys_clk);
    instrValid   <= 1'b1;
    instrWord    <= w;
    bankSelect   <= bs;
    extSetEnable <= ex;
    indexBase    <= ib;
    @(posedge sys_clk);
    // Taken here; word may change, context must hold to process phase
    instrValid <= 1'b0;
    instrWord  <= rng[15:0];
    got = 1'b0;
    for (i = 0; i < 12 && !got; i++)
    begin
      @(posedge sys_clk);
      #1;
      got = (done === 1'b1);
    end
    if (!got)
    begin
      fail_count++;
      print_verdict();
    end
    // Four phase edges after the taking edge, done seen after the last
    chk("latency", 4, 16'(i));
    // Model update from the opcode fields
    if (w[15:8] == 8'h0e)
      mW = k;
    if (w[15:8] == 8'h0d)
      mProd = mW * k;
    // Access bank split, indexed window, or banked region
    if (w[8])
      addr = (int'(bs) << 8) | k;
    else if (ex && k <= 'h5f)
      addr = (int'(ib) + k) & 'hfff;
    else
      addr = (k < 'h80) ? k : ('hf00 | k);
    chk("working", mW, 16'(working));
    chk("productHigh", mProd >> 8, 16'(productHigh));
    chk("productLow", mProd & 'hff, 16'(productLow));
    chk("memWrEn", int'(isSt), 16'(memWrEn));
    chk("busy", 0, 16'(busy));
    if (isSt)
    begin
      chk("memWrAddr", addr, 16'(memWrAddr));
      chk("memWrData", mW, 16'(memWrData));
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    int          n;
    logic [7:0]  f;
    logic [7:0]  sv [4];
    arst_n       = 1'b0;
    instrValid   = 1'b0;
    instrWord    = 16'h0000;
    bankSelect   = 4'h0;
    extSetEnable = 1'b0;
    indexBase    = 12'h000;
    fail_count   = 0;
    compares     = 0;
    mW           = 0;
    mProd        = 0;
    rng          = 32'd20;
    sv           = '{8'h5f, 8'h60, 8'h7f, 8'h80};
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    chk("working", 0, 16'(working));
    chk("done", 0, 16'(done));
    // Worked multiply, then zero products both ways
    run(16'h0ee2, 4'h3, 1'b0, 12'h100);
    run(16'h0dc4, 4'h3, 1'b0, 12'h100);
    run(16'h0d00, 4'h3, 1'b0, 12'h100);
    run(16'h0e00, 4'h3, 1'b0, 12'h100);
    run(16'h0dff, 4'h3, 1'b0, 12'h100);
    run(16'h0ea5, 4'h3, 1'b0, 12'h100);
    // Offsets at the indexed and access-bank boundaries
    for (n = 0; n < 4; n++)
    begin
      run({8'h6e, sv[n]}, 4'h9, 1'b1, 12'hfd0);
      run({8'h6e, sv[n]}, 4'h9, 1'b0, 12'hfd0);
      run({8'h6f, sv[n]}, 4'h9, 1'b1, 12'hfd0);
    end
    run(16'h6fff, 4'hf, 1'b1, 12'h000);
    // Random mix of all three opcodes plus unknown words
    for (n = 0; n < 200; n++)
    begin
      rng = xs(rng);
      f   = rng[15:8];
      case (rng[1:0])
        2'd0:    run({8'h0e, f}, rng[7:4], rng[2], rng[27:16]);
        2'd1:    run({7'h37, rng[3], f}, rng[7:4], rng[2], rng[27:16]);
        2'd2:    run({8'h0d, f}, rng[7:4], rng[2], rng[27:16]);
        default: run({8'h00, f}, rng[7:4], rng[2], rng[27:16]);
      endcase
    end
    print_verdict();
  end
endmodule
